//--- hdl/ubrg_pkg.sv
// Package of constants and types for the baud rate generator
package ubrg_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_BAUD_CTRL = 8'h00;
  localparam logic [7:0] OFF_RECV_CTRL = 8'h04;
  localparam logic [7:0] OFF_DIV_LOW = 8'h08;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h0C;
  localparam logic [7:0] OFF_XMIT_CTRL = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BC_ABD_OVF_BIT = 7;
  localparam int BC_RX_IDLE_BIT = 6;
  localparam int BC_WIDE_BIT = 3;
  localparam int TC_SYNC_BIT = 4;
  localparam int TC_HS_BIT = 2;
  localparam int TC_SHIFT_EMPTY_BIT = 1;

  // Software-writable bits of each control byte
  localparam logic [7:0] BC_WR_MASK = 8'h1B;
  localparam logic [7:0] RC_WR_MASK = 8'hF8;
  localparam logic [7:0] TC_WR_MASK = 8'hFD;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] BC_RESET = 8'h00;
  localparam logic [7:0] RC_RESET = 8'h00;
  localparam logic [7:0] TC_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // ----------------------------------------
  // Rate multipliers; the scaler's terminal count is one less than each
  // ----------------------------------------
  localparam int MULT_SLOW = 64;
  localparam int MULT_MID = 16;
  localparam int MULT_FAST = 4;
  localparam int SCALE_W = 6;

  typedef enum logic [1:0] {
    UBRG_DIV64,
    UBRG_DIV16,
    UBRG_DIV4
  } ubrg_mult_t;

  // Control bytes as seen by the serial engine
  typedef struct packed {
    logic [7:0] baud_control;
    logic [7:0] receive_control;
    logic [7:0] transmit_control;
  } ubrg_ctrl_t;

  // Receiver and transmitter status fed back into the registers
  typedef struct packed {
    logic receiver_idle_flag;
    logic abd_overflow;
    logic shift_empty;
    logic [2:0] rx_status;
  } ubrg_stat_t;

endpackage

//--- hdl/ubrg_baud_timer.sv
// Free-running baud timer with divisor compare
`timescale 1ns/1ps
module ubrg_baud_timer
  import ubrg_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [WIDTH-1:0] limit,
  // Status
  output logic [WIDTH-1:0] count,
  output logic tick
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic tick_ff;
  logic wrap;

  // Compare with >= so a lowered limit never lets the count run away
  assign wrap = (cnt_ff >= limit);
  assign nxt_cnt = (clear || wrap) ? '0 : cnt_ff + 1'b1;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= wrap && !clear;
    end
  end

  assign count = cnt_ff;
  assign tick = tick_ff;

endmodule

//--- hdl/ubrg_rate_scaler.sv
// Post-divider that turns timer ticks into bit-rate ticks
`timescale 1ns/1ps
module ubrg_rate_scaler
  import ubrg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire ubrg_mult_t mult,
  // Output
  output logic bit_tick
);

  logic [SCALE_W-1:0] cnt_ff;
  logic [SCALE_W-1:0] nxt_cnt;
  logic [SCALE_W-1:0] last;
  logic bit_ff;
  logic fire;

  assign last = (mult == UBRG_DIV64) ? SCALE_W'(MULT_SLOW - 1) :
                (mult == UBRG_DIV16) ? SCALE_W'(MULT_MID - 1) : SCALE_W'(MULT_FAST - 1);
  assign fire = step && (cnt_ff >= last);
  assign nxt_cnt = (clear || fire) ? '0 : (step ? cnt_ff + 1'b1 : cnt_ff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      bit_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      bit_ff <= fire && !clear;
    end
  end

  assign bit_tick = bit_ff;

endmodule

//--- hdl/ubrg_top.sv
// Baud rate generator with its control registers on an AHB-Lite slave
`timescale 1ns/1ps

// Contract
// - One timer, 8 or 16 bits, both modes
// - Resets narrow; wide only when select set
// - Timer free runs; divisor bytes set period
// - Async multiplier from high-speed and wide bits
// - Sync mode ignores high-speed select
// - Divisor write clears the timer at once
// - Async narrow slow: clock over 64(n+1)
// - Async wide slow: clock over 16(n+1)
// - Sync mode: clock over 4(n+1)
// - Low byte bits 7:0, high byte 15:8
// - Idle flag 1 idle, 0 receiving
// - Mode bit 1 sync, 0 async
// - High-speed bit 1 fast, 0 slow
module ubrg_top
  import ubrg_pkg::*;
#(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial engine status
  input wire ubrg_stat_t status,
  // Serial engine controls and rate ticks
  output ubrg_ctrl_t ctrl,
  output logic timer_tick,
  output logic bit_tick
);

  // ----------------------------------------
  // Bus address and data phases
  // ----------------------------------------
  logic wr_ph_ff;
  logic rd_ph_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic addr_take;
  logic [2:0] size_unused;

  // Only whole-word single transfers arrive, so size is not decoded
  assign size_unused = hsize;
  assign addr_take = hsel && htrans[1] && hready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_ph_ff <= addr_take && hwrite;
      rd_ph_ff <= addr_take && !hwrite;
      addr_ff <= addr_take ? haddr[7:0] : addr_ff;
    end
  end

  // A read waits one cycle because its data is loaded into hrdata_ff at the end of the first data cycle
  assign hreadyout = !rd_ph_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic hi_addr_zero;
  logic sel_bc;
  logic sel_rc;
  logic sel_lo;
  logic sel_hi;
  logic sel_tc;
  logic [7:0] wbyte;

  assign hi_addr_zero = 1'b1;
  assign sel_bc = (addr_ff == OFF_BAUD_CTRL);
  assign sel_rc = (addr_ff == OFF_RECV_CTRL);
  assign sel_lo = (addr_ff == OFF_DIV_LOW);
  assign sel_hi = (addr_ff == OFF_DIV_HIGH);
  assign sel_tc = (addr_ff == OFF_XMIT_CTRL);
  assign wbyte = hwdata[7:0];

  // ----------------------------------------
  // Control and divisor registers
  // ----------------------------------------
  logic [7:0] bc_ff;
  logic [7:0] rc_ff;
  logic [7:0] tc_ff;
  logic [7:0] div_lo_ff;
  logic [7:0] div_hi_ff;
  logic [7:0] nxt_bc;
  logic [7:0] nxt_rc;
  logic [7:0] nxt_tc;
  logic [7:0] nxt_div_lo;
  logic [7:0] nxt_div_hi;
  logic div_write;

  assign nxt_bc = (wr_ph_ff && sel_bc) ? (wbyte & BC_WR_MASK) : bc_ff;
  assign nxt_rc = (wr_ph_ff && sel_rc) ? (wbyte & RC_WR_MASK) : rc_ff;
  assign nxt_tc = (wr_ph_ff && sel_tc) ? (wbyte & TC_WR_MASK) : tc_ff;
  assign nxt_div_lo = (wr_ph_ff && sel_lo) ? wbyte : div_lo_ff;
  assign nxt_div_hi = (wr_ph_ff && sel_hi) ? wbyte : div_hi_ff;
  assign div_write = wr_ph_ff && (sel_lo || sel_hi);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bc_ff <= BC_RESET;
      rc_ff <= RC_RESET;
      tc_ff <= TC_RESET;
      div_lo_ff <= DIV_RESET;
      div_hi_ff <= DIV_RESET;
    end else begin
      bc_ff <= nxt_bc;
      rc_ff <= nxt_rc;
      tc_ff <= nxt_tc;
      div_lo_ff <= nxt_div_lo;
      div_hi_ff <= nxt_div_hi;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] bc_view;
  logic [7:0] rc_view;
  logic [7:0] tc_view;
  logic [7:0] rd_byte;

  // Status bits are live; reserved bits stay zero through the masks
  assign bc_view = bc_ff | {status.abd_overflow, status.receiver_idle_flag, 6'b00_0000};
  assign rc_view = rc_ff | {5'b0_0000, status.rx_status};
  assign tc_view = tc_ff | {6'b00_0000, status.shift_empty, 1'b0};
  assign rd_byte = !hi_addr_zero ? 8'h00 :
                   sel_bc ? bc_view :
                   sel_rc ? rc_view :
                   sel_lo ? div_lo_ff :
                   sel_hi ? div_hi_ff :
                   sel_tc ? tc_view : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else begin
      hrdata_ff <= rd_ph_ff ? {24'h00_0000, rd_byte} : hrdata_ff;
    end
  end

  assign ctrl = '{baud_control: bc_view, receive_control: rc_view, transmit_control: tc_view};

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  logic sync_mode;
  logic high_speed_select;
  logic wide_counter_select;
  logic [DIV_W-1:0] eff_div;
  ubrg_mult_t mult_sel;

  assign sync_mode = tc_ff[TC_SYNC_BIT];
  assign high_speed_select = tc_ff[TC_HS_BIT];
  assign wide_counter_select = bc_ff[BC_WIDE_BIT];
  // Narrow counting drops the high byte entirely
  assign eff_div = wide_counter_select ? DIV_W'({div_hi_ff, div_lo_ff}) : DIV_W'(div_lo_ff);

  // Sync mode has one fixed multiplier, whatever the speed bit says
  assign mult_sel = sync_mode ? UBRG_DIV4 :
                    (!wide_counter_select && !high_speed_select) ? UBRG_DIV64 :
                    (wide_counter_select && high_speed_select) ? UBRG_DIV4 :
                    UBRG_DIV16;

  // ----------------------------------------
  // Timer and scaler
  // ----------------------------------------
  logic [DIV_W-1:0] tmr_count;

  // One shared timer serves both modes and never stops
  ubrg_baud_timer #(
    .WIDTH(DIV_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(div_write),
    .limit(eff_div),
    .count(tmr_count),
    .tick(timer_tick)
  );

  // Scaler is cleared too, so the first new bit is a full period
  ubrg_rate_scaler u_scaler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(div_write),
    .step(timer_tick),
    .mult(mult_sel),
    .bit_tick(bit_tick)
  );

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  logic [22:0] gap_ff;
  logic gap_ok_ff;
  logic [10:0] cfg_ff;
  logic [10:0] cfg_now;
  logic [22:0] n_plus_one;
  logic [16:0] tgap_ff;
  logic tok_ff;

  assign cfg_now = {sync_mode, high_speed_select, wide_counter_select, eff_div[7:0]};
  assign n_plus_one = 23'(eff_div) + 23'd1;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 23'h00_0001;
      gap_ok_ff <= 1'b0;
      cfg_ff <= 11'h000;
    end else begin
      gap_ff <= bit_tick ? 23'h00_0001 : gap_ff + 23'h00_0001;
      gap_ok_ff <= (div_write || cfg_now != cfg_ff) ? 1'b0 : (bit_tick ? 1'b1 : gap_ok_ff);
      cfg_ff <= cfg_now;
    end
  end

  // Timer spacing, trusted only after a full undisturbed period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgap_ff <= 17'h0_0001;
      tok_ff <= 1'b0;
    end else begin
      tgap_ff <= timer_tick ? 17'h0_0001 : tgap_ff + 17'h0_0001;
      tok_ff <= (div_write || cfg_now != cfg_ff) ? 1'b0 : (timer_tick ? 1'b1 : tok_ff);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_steady_tick;
    bit_tick && gap_ok_ff && !div_write && (cfg_now == cfg_ff);
  endsequence

  a_rate_async_slow: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_steady_tick and (!sync_mode && !wide_counter_select && !high_speed_select)
      |-> gap_ff == 23'(MULT_SLOW) * n_plus_one)
    else $error("Async narrow slow period wrong");

  a_rate_async_wide: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_steady_tick and (!sync_mode && wide_counter_select && !high_speed_select)
      |-> gap_ff == 23'(MULT_MID) * n_plus_one)
    else $error("Async wide slow period wrong");

  a_rate_narrow_fast: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_steady_tick and (!sync_mode && !wide_counter_select && high_speed_select)
      |-> gap_ff == 23'(MULT_MID) * n_plus_one)
    else $error("Async narrow fast period wrong");

  a_rate_wide_fast: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_steady_tick and (!sync_mode && wide_counter_select && high_speed_select)
      |-> gap_ff == 23'(MULT_FAST) * n_plus_one)
    else $error("Async wide fast period wrong");

  a_rate_sync_mode: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_steady_tick and sync_mode |-> gap_ff == 23'(MULT_FAST) * n_plus_one)
    else $error("Sync period wrong");

  a_sync_ignores_hs: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sync_mode |-> mult_sel == UBRG_DIV4)
    else $error("Sync multiplier follows speed bit");

  a_write_clears_timer: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    div_write |=> (tmr_count == '0) && !timer_tick ##1 !bit_tick)
    else $error("Divisor write did not clear timer");

  a_narrow_low_only: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !wide_counter_select |-> eff_div == DIV_W'(div_lo_ff))
    else $error("High byte used in narrow mode");

  a_divisor_join: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wide_counter_select |-> (eff_div[7:0] == div_lo_ff) && (eff_div[15:8] == div_hi_ff))
    else $error("Divisor bytes joined wrongly");

  a_timer_bounded: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    timer_tick |-> $past(tmr_count) >= $past(eff_div) || $past(div_write))
    else $error("Timer wrapped early");

  a_idle_flag_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_ph_ff && sel_bc |=> hrdata[BC_RX_IDLE_BIT] == $past(status.receiver_idle_flag))
    else $error("Idle flag read wrong");

  a_mode_bit_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_ph_ff && sel_tc |=> sync_mode == $past(hwdata[TC_SYNC_BIT]))
    else $error("Mode bit not taken");

  a_speed_bit_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_ph_ff && sel_tc |=> high_speed_select == $past(hwdata[TC_HS_BIT]))
    else $error("Speed bit not taken");

  a_reset_narrow: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(wide_counter_select) |-> $past(wr_ph_ff && sel_bc))
    else $error("Wide mode without a write");

  a_timer_period: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    timer_tick && tok_ff && !div_write && (cfg_now == cfg_ff) |-> 23'(tgap_ff) == n_plus_one)
    else $error("Timer period wrong");

  a_bit_tick_pulse: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    bit_tick |=> !bit_tick)
    else $error("Bit tick longer than one cycle");

  a_idle_in_ctrl: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl.baud_control[BC_RX_IDLE_BIT] == status.receiver_idle_flag)
    else $error("Idle flag not shown to engine");

endmodule

//--- testbench/ubrg_tb.sv
// Self-checking testbench for the baud rate generator and its registers
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end

module tb
  import ubrg_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hready;
  logic hreadyout;
  logic hresp;
  ubrg_stat_t status;
  ubrg_ctrl_t ctrl;
  logic timer_tick;
  logic bit_tick;
  int errors;
  int compares;
  int gap;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  ubrg_top #(
    .DIV_W(16)
  ) uut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .status(status),
    .ctrl(ctrl),
    .timer_tick(timer_tick),
    .bit_tick(bit_tick)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Bus tasks, entered just after a rising edge
  // ----------------------------------------
  // Waits as long as the slave stalls; only the watchdog ends a hang
  task automatic wait_ready;
    do begin
      @(posedge ref_clk);
    end while (hready !== 1'b1);
  endtask

  task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, addr};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, data};
    wait_ready();
  endtask

  task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, addr};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    wait_ready();
    htrans <= 2'b00;
    wait_ready();
    data = hrdata;
  endtask

  task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [31:0] rd;
    bus_read(addr, rd);
    `CHK(rd, {24'h00_0000, exp})
  endtask

  // Cycles until the next sampled tick, bounded
  task automatic tick_gap(input bit use_bit, output int g);
    int c;
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (!((use_bit ? bit_tick : timer_tick) === 1'b1) && c < 20000);
    g = c;
    if (c >= 20000) begin
      errors++;
      $display("CHECK FAILED at %0t ns: tick never came", $time);
    end
  endtask

  // ----------------------------------------
  // Rate measurement
  // ----------------------------------------
  function automatic int mult(input bit s, input bit w, input bit h);
    if (s) begin
      return 4;
    end
    if (w) begin
      return h ? 4 : 16;
    end
    return h ? 16 : 64;
  endfunction

  task automatic check_rate(input bit s, input bit w, input bit h, input logic [7:0] hi, input logic [7:0] lo);
    int n;
    int g;
    n = w ? int'({hi, lo}) : int'(lo);
    bus_write(OFF_XMIT_CTRL, {3'b000, s, 1'b0, h, 2'b00});
    bus_write(OFF_BAUD_CTRL, {4'h0, w, 3'b000});
    bus_write(OFF_DIV_HIGH, hi);
    bus_write(OFF_DIV_LOW, lo);
    // First period after a mode change may be irregular
    tick_gap(1'b1, g);
    tick_gap(1'b1, g);
    `CHK(g, mult(s, w, h) * (n + 1))
    tick_gap(1'b0, g);
    tick_gap(1'b0, g);
    `CHK(g, n + 1)
  endtask

  task automatic conclude;
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    compares = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    status = '{receiver_idle_flag: 1'b1, abd_overflow: 1'b0, shift_empty: 1'b1, rx_status: 3'b000};
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    tick_gap(1'b1, gap);
    tick_gap(1'b1, gap);
    `CHK(gap, 64)
    chk_reg(OFF_BAUD_CTRL, BC_RESET | 8'h40);
    chk_reg(OFF_XMIT_CTRL, TC_RESET | 8'h02);
    chk_reg(OFF_RECV_CTRL, RC_RESET);
    chk_reg(OFF_DIV_LOW, DIV_RESET);
    chk_reg(OFF_DIV_HIGH, DIV_RESET);
    // Read-only status bits must ignore writes and follow the inputs
    status <= '{receiver_idle_flag: 1'b0, abd_overflow: 1'b0, shift_empty: 1'b0, rx_status: 3'b101};
    bus_write(OFF_BAUD_CTRL, 8'hFF);
    bus_write(OFF_RECV_CTRL, 8'hFF);
    bus_write(OFF_XMIT_CTRL, 8'hFF);
    bus_write(8'h14, 8'hFF);
    chk_reg(OFF_BAUD_CTRL, BC_WR_MASK);
    chk_reg(OFF_RECV_CTRL, RC_WR_MASK | 8'h05);
    chk_reg(OFF_XMIT_CTRL, TC_WR_MASK);
    chk_reg(8'h14, 8'h00);
    `CHK(ctrl.baud_control, BC_WR_MASK)
    `CHK(ctrl.receive_control, RC_WR_MASK | 8'h05)
    `CHK({hresp, ctrl.transmit_control}, {1'b0, TC_WR_MASK})
    bus_write(OFF_DIV_LOW, 8'hA5);
    bus_write(OFF_DIV_HIGH, 8'h3C);
    chk_reg(OFF_DIV_LOW, 8'hA5);
    chk_reg(OFF_DIV_HIGH, 8'h3C);
    status <= '{receiver_idle_flag: 1'b1, abd_overflow: 1'b0, shift_empty: 1'b1, rx_status: 3'b000};
    chk_reg(OFF_BAUD_CTRL, BC_WR_MASK | 8'h40);
    // Every mode combination except sync wide slow; narrow rows carry a nonzero high byte
    check_rate(1'b0, 1'b0, 1'b0, 8'h05, 8'h03);
    check_rate(1'b0, 1'b0, 1'b1, 8'h05, 8'h03);
    check_rate(1'b0, 1'b1, 1'b0, 8'h01, 8'h02);
    check_rate(1'b0, 1'b1, 1'b1, 8'h01, 8'h02);
    check_rate(1'b1, 1'b0, 1'b0, 8'h07, 8'h09);
    check_rate(1'b1, 1'b0, 1'b1, 8'h07, 8'h09);
    check_rate(1'b1, 1'b1, 1'b1, 8'h01, 8'h00);
    // Divisor write must not wait out a long old count
    bus_write(OFF_XMIT_CTRL, 8'h00);
    bus_write(OFF_BAUD_CTRL, 8'h08);
    bus_write(OFF_DIV_HIGH, 8'hFF);
    bus_write(OFF_DIV_LOW, 8'hFF);
    repeat (200) @(posedge ref_clk);
    bus_write(OFF_BAUD_CTRL, 8'h00);
    // Old count is below the new limit, so only a clear gives a full first period
    bus_write(OFF_DIV_LOW, 8'hFE);
    tick_gap(1'b0, gap);
    `CHK(gap, 254 + 2)
    conclude();
  end

  // Whole run needs about 15500 cycles
  initial begin
    #480_000;
    errors++;
    $display("CHECK FAILED at %0t ns: watchdog expired", $time);
    conclude();
  end

endmodule
